// ==== core/rtc_value_map.svh ====
`ifndef RTC_VALUE_MAP_SVH
`define RTC_VALUE_MAP_SVH

// Register byte offsets on the APB bus.
`define OFS_CLOCK_CONTROL 12'h000
`define OFS_ALARM_CONTROL 12'h004
`define OFS_TIME_WINDOW_LOW 12'h008
`define OFS_TIME_WINDOW_HIGH 12'h00C
`define OFS_ALARM_WINDOW_LOW 12'h010
`define OFS_ALARM_WINDOW_HIGH 12'h014

// Control register bit positions.
`define BIT_WRITE_ENABLE 13
`define BIT_HALF_SECOND 11
`define POS_WINDOW_POINTER 8
`define BIT_ALARM_MATCH 0

// Reset values of control state.
`define RST_WINDOW_POINTER 2'h0
`define RST_WRITE_ENABLE 1'h0

// Digit positions inside a 16-bit value register image.
`define POS_MONTH_TENS 12
`define POS_MONTH_UNITS 8
`define POS_DAY_TENS 4
`define POS_DAY_UNITS 0
`define POS_WEEKDAY 8
`define POS_HOUR_TENS 4
`define POS_HOUR_UNITS 0
`define POS_MINUTE_TENS 12
`define POS_MINUTE_UNITS 8
`define POS_SECOND_TENS 4
`define POS_SECOND_UNITS 0
`define POS_YEAR_TENS 4
`define POS_YEAR_UNITS 0

// Rollover limits: tens at its top, units at its top, units after wrap.
`define MONTH_TENS_MAX 1
`define MONTH_UNITS_MAX 2
`define MONTH_UNITS_MIN 1
`define DAY_TENS_MAX 3
`define DAY_UNITS_MAX 1
`define DAY_UNITS_MIN 1
`define HOUR_TENS_MAX 2
`define HOUR_UNITS_MAX 3
`define SIXTY_TENS_MAX 5
`define DIGIT_MAX 9
`define DIGIT_MIN 0
`define WEEKDAY_MAX 3'h6

`endif

// ==== core/rtc_value_pkg.sv ====
`default_nettype none

package rtc_value_pkg;

	typedef struct packed {
		logic monthTensDigit;
		logic [3:0] monthUnitsDigit;
		logic [1:0] dayTensDigit;
		logic [3:0] dayUnitsDigit;
		logic [2:0] weekdayDigit;
		logic [1:0] hourTensDigit;
		logic [3:0] hourUnitsDigit;
		logic [2:0] minuteTensDigit;
		logic [3:0] minuteUnitsDigit;
		logic [2:0] secondTensDigit;
		logic [3:0] secondUnitsDigit;
	} time_value_type;

	typedef enum logic [1:0] {
		SEL_MINUTE_SECOND = 2'h0,
		SEL_WEEKDAY_HOUR = 2'h1,
		SEL_MONTH_DAY = 2'h2,
		SEL_YEAR = 2'h3
	} window_sel_type;

endpackage

`default_nettype wire

// ==== core/rtc_pin_sync.sv ====
`default_nettype none

module rtc_pin_sync (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic pinIn, // asynchronous pin level
	output logic level, // filtered level
	output logic rise // one-cycle pulse on a filtered rising edge
);

	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic level_reg;
	logic level_next;

	always_comb
	begin
		stage_next = {stage_reg[1:0], pinIn};
		level_next = level_reg;
		// The first stage only feeds the second; the decision looks at stages two and three.
		if (stage_reg[1] == stage_reg[2])
		begin
			level_next = stage_reg[2];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			stage_reg <= 3'h0;
			level_reg <= 1'h0;
		end
		else
		begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
	assign rise = level_next & ~level_reg;

endmodule

`default_nettype wire

// ==== core/rtc_bcd_field.sv ====
`default_nettype none

module rtc_bcd_field #(
	parameter int TENS_WIDTH = 3,
	parameter int TENS_MAX = 5,
	parameter int UNITS_MAX = 9,
	parameter int UNITS_MIN = 0
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic inc, // advance by one
	input wire logic load, // software write of this field
	input wire logic [TENS_WIDTH-1:0] loadTens, // written tens digit
	input wire logic [3:0] loadUnits, // written units digit
	output logic [TENS_WIDTH-1:0] tens, // tens digit
	output logic [3:0] units, // units digit
	output logic carry // pulse: field wrapped this cycle
);

	if (TENS_WIDTH < 1 || TENS_WIDTH > 4 || TENS_MAX >= (1 << TENS_WIDTH) || UNITS_MAX > 9 || UNITS_MIN > 1)
	begin : badParams
		$error("rtc_bcd_field parameters out of range");
	end

	logic [TENS_WIDTH-1:0] tens_reg;
	logic [TENS_WIDTH-1:0] tens_next;
	logic [3:0] units_reg;
	logic [3:0] units_next;
	logic atTop;

	always_comb
	begin
		tens_next = tens_reg;
		units_next = units_reg;
		atTop = (tens_reg >= TENS_WIDTH'(TENS_MAX)) && (units_reg >= 4'(UNITS_MAX));
		carry = 1'h0;
		// A write beats a count arriving in the same cycle.
		if (load)
		begin
			tens_next = loadTens;
			units_next = loadUnits;
		end
		else if (inc)
		begin
			if (atTop)
			begin
				tens_next = '0;
				units_next = 4'(UNITS_MIN);
				carry = 1'h1;
			end
			else if (units_reg >= 4'h9)
			begin
				units_next = 4'h0;
				tens_next = tens_reg + TENS_WIDTH'(1);
			end
			else
			begin
				units_next = units_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			tens_reg <= '0;
			units_reg <= 4'(UNITS_MIN);
		end
		else
		begin
			tens_reg <= tens_next;
			units_reg <= units_next;
		end
	end

	assign tens = tens_reg;
	assign units = units_reg;

endmodule

`default_nettype wire

// ==== core/rtc_bcd_time_alarm_values.sv ====
`default_nettype none
`include "rtc_value_map.svh"

module rtc_bcd_time_alarm_values #(
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction, high for write
	input wire logic [ADDR_WIDTH-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic timebaseTick, // asynchronous half-second timebase
	output rtc_value_pkg::time_value_type timeNow, // running time
	output logic [7:0] yearNow, // running year, BCD
	output logic alarmMatch // alarm equals time
);

	if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32)
	begin : badWidth
		$error("ADDR_WIDTH must hold the register map");
	end

	logic access;
	logic setup;
	logic [11:0] addr;
	logic mapped;
	logic wrCtrl;
	logic wrAlarmCtrl;
	logic wrTimeLow;
	logic wrTimeHigh;
	logic wrAlarmLow;
	logic wrAlarmHigh;
	logic touchTimeHigh;
	logic touchAlarmHigh;
	logic [15:0] imgLow;
	logic [15:0] imgHigh;
	logic halfTick;
	logic secondTick;

	logic writeEnable_reg;
	logic writeEnable_next;
	rtc_value_pkg::window_sel_type timePtr_reg;
	rtc_value_pkg::window_sel_type timePtr_next;
	rtc_value_pkg::window_sel_type alarmPtr_reg;
	rtc_value_pkg::window_sel_type alarmPtr_next;
	logic halfSecond_reg;
	logic halfSecond_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [2:0] weekday_reg;
	logic [2:0] weekday_next;
	rtc_value_pkg::time_value_type alarm_reg;
	rtc_value_pkg::time_value_type alarm_next;
	logic match_reg;
	logic match_next;

	rtc_value_pkg::time_value_type now;
	logic [3:0] yearTens;
	logic [3:0] yearUnits;
	logic [15:0] timeImg;
	logic [15:0] alarmImg;
	logic wrSec;
	logic wrMin;
	logic wrHour;
	logic wrWeekday;
	logic wrDay;
	logic wrMonth;
	logic wrYear;
	logic secCarry;
	logic minCarry;
	logic hourCarry;
	logic dayCarry;
	logic monthCarry;

	assign access = psel & penable;
	assign setup = psel & ~penable;
	assign addr = 12'(paddr);
	assign pready = 1'h1;
	assign mapped = (addr == `OFS_CLOCK_CONTROL) || (addr == `OFS_ALARM_CONTROL)
		|| (addr == `OFS_TIME_WINDOW_LOW) || (addr == `OFS_TIME_WINDOW_HIGH)
		|| (addr == `OFS_ALARM_WINDOW_LOW) || (addr == `OFS_ALARM_WINDOW_HIGH);
	assign pslverr = access & ~mapped;
	assign prdata = prdata_reg;

	assign wrCtrl = access & pwrite & (addr == `OFS_CLOCK_CONTROL);
	assign wrAlarmCtrl = access & pwrite & (addr == `OFS_ALARM_CONTROL);
	assign wrTimeLow = access & pwrite & (addr == `OFS_TIME_WINDOW_LOW);
	assign wrTimeHigh = access & pwrite & (addr == `OFS_TIME_WINDOW_HIGH);
	assign wrAlarmLow = access & pwrite & (addr == `OFS_ALARM_WINDOW_LOW);
	assign wrAlarmHigh = access & pwrite & (addr == `OFS_ALARM_WINDOW_HIGH);
	assign touchTimeHigh = access & (addr == `OFS_TIME_WINDOW_HIGH);
	assign touchAlarmHigh = access & (addr == `OFS_ALARM_WINDOW_HIGH);

	// Each window carries one byte; placing it in a 16-bit image lets one set of positions serve both halves.
	assign imgLow = {8'h00, pwdata[7:0]};
	assign imgHigh = {pwdata[7:0], 8'h00};

	assign wrSec = wrTimeLow & (timePtr_reg == rtc_value_pkg::SEL_MINUTE_SECOND);
	assign wrMin = wrTimeHigh & (timePtr_reg == rtc_value_pkg::SEL_MINUTE_SECOND);
	assign wrHour = wrTimeLow & writeEnable_reg & (timePtr_reg == rtc_value_pkg::SEL_WEEKDAY_HOUR);
	assign wrWeekday = wrTimeHigh & writeEnable_reg & (timePtr_reg == rtc_value_pkg::SEL_WEEKDAY_HOUR);
	assign wrDay = wrTimeLow & writeEnable_reg & (timePtr_reg == rtc_value_pkg::SEL_MONTH_DAY);
	assign wrMonth = wrTimeHigh & writeEnable_reg & (timePtr_reg == rtc_value_pkg::SEL_MONTH_DAY);
	assign wrYear = wrTimeLow & writeEnable_reg & (timePtr_reg == rtc_value_pkg::SEL_YEAR);

	rtc_pin_sync tickSync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pinIn(timebaseTick),
		.level(),
		.rise(halfTick)
	);

	// The second advances on the tick that ends the second half of a second.
	assign secondTick = halfTick & halfSecond_reg;

	rtc_bcd_field #(.TENS_WIDTH(3), .TENS_MAX(`SIXTY_TENS_MAX), .UNITS_MAX(`DIGIT_MAX), .UNITS_MIN(`DIGIT_MIN)) secField (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inc(secondTick),
		.load(wrSec),
		.loadTens(imgLow[`POS_SECOND_TENS +: 3]),
		.loadUnits(imgLow[`POS_SECOND_UNITS +: 4]),
		.tens(now.secondTensDigit),
		.units(now.secondUnitsDigit),
		.carry(secCarry)
	);

	rtc_bcd_field #(.TENS_WIDTH(3), .TENS_MAX(`SIXTY_TENS_MAX), .UNITS_MAX(`DIGIT_MAX), .UNITS_MIN(`DIGIT_MIN)) minField (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inc(secCarry),
		.load(wrMin),
		.loadTens(imgHigh[`POS_MINUTE_TENS +: 3]),
		.loadUnits(imgHigh[`POS_MINUTE_UNITS +: 4]),
		.tens(now.minuteTensDigit),
		.units(now.minuteUnitsDigit),
		.carry(minCarry)
	);

	rtc_bcd_field #(.TENS_WIDTH(2), .TENS_MAX(`HOUR_TENS_MAX), .UNITS_MAX(`HOUR_UNITS_MAX), .UNITS_MIN(`DIGIT_MIN)) hourField (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inc(minCarry),
		.load(wrHour),
		.loadTens(imgLow[`POS_HOUR_TENS +: 2]),
		.loadUnits(imgLow[`POS_HOUR_UNITS +: 4]),
		.tens(now.hourTensDigit),
		.units(now.hourUnitsDigit),
		.carry(hourCarry)
	);

	rtc_bcd_field #(.TENS_WIDTH(2), .TENS_MAX(`DAY_TENS_MAX), .UNITS_MAX(`DAY_UNITS_MAX), .UNITS_MIN(`DAY_UNITS_MIN)) dayField (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inc(hourCarry),
		.load(wrDay),
		.loadTens(imgLow[`POS_DAY_TENS +: 2]),
		.loadUnits(imgLow[`POS_DAY_UNITS +: 4]),
		.tens(now.dayTensDigit),
		.units(now.dayUnitsDigit),
		.carry(dayCarry)
	);

	rtc_bcd_field #(.TENS_WIDTH(1), .TENS_MAX(`MONTH_TENS_MAX), .UNITS_MAX(`MONTH_UNITS_MAX), .UNITS_MIN(`MONTH_UNITS_MIN)) monthField (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inc(dayCarry),
		.load(wrMonth),
		.loadTens(imgHigh[`POS_MONTH_TENS +: 1]),
		.loadUnits(imgHigh[`POS_MONTH_UNITS +: 4]),
		.tens(now.monthTensDigit),
		.units(now.monthUnitsDigit),
		.carry(monthCarry)
	);

	rtc_bcd_field #(.TENS_WIDTH(4), .TENS_MAX(`DIGIT_MAX), .UNITS_MAX(`DIGIT_MAX), .UNITS_MIN(`DIGIT_MIN)) yearField (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inc(monthCarry),
		.load(wrYear),
		.loadTens(imgLow[`POS_YEAR_TENS +: 4]),
		.loadUnits(imgLow[`POS_YEAR_UNITS +: 4]),
		.tens(yearTens),
		.units(yearUnits),
		.carry()
	);

	assign now.weekdayDigit = weekday_reg;
	assign timeNow = now;
	assign yearNow = {yearTens, yearUnits};
	assign alarmMatch = match_reg;

	// Read images of the selected value registers; unassigned bits stay zero.
	always_comb
	begin
		timeImg = 16'h0000;
		alarmImg = 16'h0000;
		case (timePtr_reg)
			rtc_value_pkg::SEL_MINUTE_SECOND:
			begin
				timeImg[`POS_MINUTE_TENS +: 3] = now.minuteTensDigit;
				timeImg[`POS_MINUTE_UNITS +: 4] = now.minuteUnitsDigit;
				timeImg[`POS_SECOND_TENS +: 3] = now.secondTensDigit;
				timeImg[`POS_SECOND_UNITS +: 4] = now.secondUnitsDigit;
			end
			rtc_value_pkg::SEL_WEEKDAY_HOUR:
			begin
				timeImg[`POS_WEEKDAY +: 3] = now.weekdayDigit;
				timeImg[`POS_HOUR_TENS +: 2] = now.hourTensDigit;
				timeImg[`POS_HOUR_UNITS +: 4] = now.hourUnitsDigit;
			end
			rtc_value_pkg::SEL_MONTH_DAY:
			begin
				timeImg[`POS_MONTH_TENS +: 1] = now.monthTensDigit;
				timeImg[`POS_MONTH_UNITS +: 4] = now.monthUnitsDigit;
				timeImg[`POS_DAY_TENS +: 2] = now.dayTensDigit;
				timeImg[`POS_DAY_UNITS +: 4] = now.dayUnitsDigit;
			end
			default:
			begin
				timeImg[`POS_YEAR_TENS +: 4] = yearTens;
				timeImg[`POS_YEAR_UNITS +: 4] = yearUnits;
			end
		endcase
		case (alarmPtr_reg)
			rtc_value_pkg::SEL_MINUTE_SECOND:
			begin
				alarmImg[`POS_MINUTE_TENS +: 3] = alarm_reg.minuteTensDigit;
				alarmImg[`POS_MINUTE_UNITS +: 4] = alarm_reg.minuteUnitsDigit;
				alarmImg[`POS_SECOND_TENS +: 3] = alarm_reg.secondTensDigit;
				alarmImg[`POS_SECOND_UNITS +: 4] = alarm_reg.secondUnitsDigit;
			end
			rtc_value_pkg::SEL_WEEKDAY_HOUR:
			begin
				alarmImg[`POS_WEEKDAY +: 3] = alarm_reg.weekdayDigit;
				alarmImg[`POS_HOUR_TENS +: 2] = alarm_reg.hourTensDigit;
				alarmImg[`POS_HOUR_UNITS +: 4] = alarm_reg.hourUnitsDigit;
			end
			rtc_value_pkg::SEL_MONTH_DAY:
			begin
				alarmImg[`POS_MONTH_TENS +: 1] = alarm_reg.monthTensDigit;
				alarmImg[`POS_MONTH_UNITS +: 4] = alarm_reg.monthUnitsDigit;
				alarmImg[`POS_DAY_TENS +: 2] = alarm_reg.dayTensDigit;
				alarmImg[`POS_DAY_UNITS +: 4] = alarm_reg.dayUnitsDigit;
			end
			default:
			begin
				alarmImg = 16'h0000;
			end
		endcase
	end

	always_comb
	begin
		writeEnable_next = writeEnable_reg;
		timePtr_next = timePtr_reg;
		alarmPtr_next = alarmPtr_reg;
		halfSecond_next = halfSecond_reg;
		weekday_next = weekday_reg;
		alarm_next = alarm_reg;
		prdata_next = prdata_reg;

		if (wrCtrl)
		begin
			writeEnable_next = pwdata[`BIT_WRITE_ENABLE];
			timePtr_next = rtc_value_pkg::window_sel_type'(pwdata[`POS_WINDOW_POINTER +: 2]);
		end
		else if (touchTimeHigh && timePtr_reg != rtc_value_pkg::SEL_MINUTE_SECOND)
		begin
			timePtr_next = rtc_value_pkg::window_sel_type'(timePtr_reg - 2'h1);
		end

		if (wrAlarmCtrl)
		begin
			alarmPtr_next = rtc_value_pkg::window_sel_type'(pwdata[`POS_WINDOW_POINTER +: 2]);
		end
		else if (touchAlarmHigh && alarmPtr_reg != rtc_value_pkg::SEL_MINUTE_SECOND)
		begin
			alarmPtr_next = rtc_value_pkg::window_sel_type'(alarmPtr_reg - 2'h1);
		end

		if (wrSec)
		begin
			halfSecond_next = 1'h0;
		end
		// A tick in the same cycle as the clear still toggles the flag.
		if (halfTick)
		begin
			halfSecond_next = ~halfSecond_reg;
		end

		if (wrWeekday)
		begin
			weekday_next = imgHigh[`POS_WEEKDAY +: 3];
		end
		else if (hourCarry)
		begin
			weekday_next = (weekday_reg >= `WEEKDAY_MAX) ? 3'h0 : weekday_reg + 3'h1;
		end

		if (wrAlarmLow && alarmPtr_reg == rtc_value_pkg::SEL_MINUTE_SECOND)
		begin
			alarm_next.secondTensDigit = imgLow[`POS_SECOND_TENS +: 3];
			alarm_next.secondUnitsDigit = imgLow[`POS_SECOND_UNITS +: 4];
		end
		if (wrAlarmHigh && alarmPtr_reg == rtc_value_pkg::SEL_MINUTE_SECOND)
		begin
			alarm_next.minuteTensDigit = imgHigh[`POS_MINUTE_TENS +: 3];
			alarm_next.minuteUnitsDigit = imgHigh[`POS_MINUTE_UNITS +: 4];
		end
		if (wrAlarmLow && writeEnable_reg && alarmPtr_reg == rtc_value_pkg::SEL_WEEKDAY_HOUR)
		begin
			alarm_next.hourTensDigit = imgLow[`POS_HOUR_TENS +: 2];
			alarm_next.hourUnitsDigit = imgLow[`POS_HOUR_UNITS +: 4];
		end
		if (wrAlarmHigh && writeEnable_reg && alarmPtr_reg == rtc_value_pkg::SEL_WEEKDAY_HOUR)
		begin
			alarm_next.weekdayDigit = imgHigh[`POS_WEEKDAY +: 3];
		end
		if (wrAlarmLow && writeEnable_reg && alarmPtr_reg == rtc_value_pkg::SEL_MONTH_DAY)
		begin
			alarm_next.dayTensDigit = imgLow[`POS_DAY_TENS +: 2];
			alarm_next.dayUnitsDigit = imgLow[`POS_DAY_UNITS +: 4];
		end
		if (wrAlarmHigh && writeEnable_reg && alarmPtr_reg == rtc_value_pkg::SEL_MONTH_DAY)
		begin
			alarm_next.monthTensDigit = imgHigh[`POS_MONTH_TENS +: 1];
			alarm_next.monthUnitsDigit = imgHigh[`POS_MONTH_UNITS +: 4];
		end

		if (setup)
		begin
			prdata_next = 32'h00000000;
			case (addr)
				`OFS_CLOCK_CONTROL:
				begin
					prdata_next[`BIT_WRITE_ENABLE] = writeEnable_reg;
					prdata_next[`BIT_HALF_SECOND] = halfSecond_reg;
					prdata_next[`POS_WINDOW_POINTER +: 2] = timePtr_reg;
				end
				`OFS_ALARM_CONTROL:
				begin
					prdata_next[`POS_WINDOW_POINTER +: 2] = alarmPtr_reg;
					prdata_next[`BIT_ALARM_MATCH] = match_reg;
				end
				`OFS_TIME_WINDOW_LOW: prdata_next[7:0] = timeImg[7:0];
				`OFS_TIME_WINDOW_HIGH: prdata_next[7:0] = timeImg[15:8];
				`OFS_ALARM_WINDOW_LOW: prdata_next[7:0] = alarmImg[7:0];
				`OFS_ALARM_WINDOW_HIGH: prdata_next[7:0] = alarmImg[15:8];
				default: prdata_next = 32'h00000000;
			endcase
		end

		match_next = (alarm_reg == now);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			writeEnable_reg <= `RST_WRITE_ENABLE;
			timePtr_reg <= rtc_value_pkg::window_sel_type'(`RST_WINDOW_POINTER);
			alarmPtr_reg <= rtc_value_pkg::window_sel_type'(`RST_WINDOW_POINTER);
			halfSecond_reg <= 1'h0;
			weekday_reg <= 3'h0;
			alarm_reg <= '0;
			match_reg <= 1'h0;
			prdata_reg <= 32'h00000000;
		end
		else
		begin
			writeEnable_reg <= writeEnable_next;
			timePtr_reg <= timePtr_next;
			alarmPtr_reg <= alarmPtr_next;
			halfSecond_reg <= halfSecond_next;
			weekday_reg <= weekday_next;
			alarm_reg <= alarm_next;
			match_reg <= match_next;
			prdata_reg <= prdata_next;
		end
	end

endmodule

`default_nettype wire

// ==== verif/rtc_values_checker.sv ====
`default_nettype none

module rtc_values_checker #(
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clk_sys, // clock
	input wire logic rst_n, // reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [ADDR_WIDTH-1:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic timebaseTick, // timebase pin
	input wire rtc_value_pkg::time_value_type timeNow, // running time
	input wire logic [7:0] yearNow, // running year
	input wire logic alarmMatch // alarm equals time
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic access;
	logic [3:0] quietCnt_reg;
	logic [3:0] quietCnt_next;
	assign access = psel && penable;
	// Only a long low spell counts as quiet: a rise may still be in the synchroniser for a few cycles.
	always_comb
	begin
		quietCnt_next = quietCnt_reg;
		if (timebaseTick)
			quietCnt_next = 4'h0;
		else if (quietCnt_reg != 4'hF)
			quietCnt_next = quietCnt_reg + 4'h1;
	end
	always_ff @(posedge clk_sys)
	begin
		quietCnt_reg <= rst_n ? quietCnt_next : 4'h0;
	end
	a_ready_high: assert property (access |-> pready) else $error("ready low in access");
	a_error_mapped: assert property (access && paddr[11:0] <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on a mapped address");
	a_error_unmapped: assert property (access && paddr[11:0] >= 12'h018 |-> pslverr)
		else $error("no error on an unmapped address");
	// Control registers carry bits above the byte; only the value windows are one byte wide.
	a_upper_zero: assert property (access && !pwrite && paddr[11:0] >= 12'h008 |-> prdata[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	a_weekday_range: assert property (timeNow.weekdayDigit <= 3'h6)
		else $error("weekday out of range");
	a_digit_range: assert property (timeNow.hourTensDigit <= 2'h2 && timeNow.minuteTensDigit <= 3'h5
		&& timeNow.secondTensDigit <= 3'h5) else $error("tens digit out of range");
	a_time_steady: assert property (quietCnt_reg >= 4'h6 && !$past(access && pwrite) |-> $stable(timeNow))
		else $error("time moved without tick or write");
	a_second_step: assert property ($changed(timeNow.secondUnitsDigit) && !$past(access && pwrite)
		|-> timeNow.secondUnitsDigit == ($past(timeNow.secondUnitsDigit) == 4'h9 ? 4'h0
		: $past(timeNow.secondUnitsDigit) + 4'h1)) else $error("seconds did not count by one");
	c_write: cover property (access && pwrite);
	c_error: cover property (pslverr);
	c_match: cover property (alarmMatch);
	c_minute: cover property ($changed(timeNow.minuteUnitsDigit));
endmodule

bind rtc_bcd_time_alarm_values rtc_values_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_rtc_values_checker (
	.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timebaseTick(timebaseTick), .timeNow(timeNow), .yearNow(yearNow), .alarmMatch(alarmMatch));

`default_nettype wire

// ==== verif/rtc_bcd_time_alarm_values_tb.sv ====
`default_nettype none
`include "rtc_value_map.svh"

module rtc_bcd_time_alarm_values_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timebaseTick = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, alarmMatch, errSeen;
	logic [7:0] yearNow;
	rtc_value_pkg::time_value_type timeNow, expTime, other;
	int bad_count = 0, comparisons = 0, seed = 32'h6D3EADFF;
	// Unassigned bits of each window byte, set on writes so that a leak shows on read-back.
	logic [7:0] junkBits [6] = '{8'hC0, 8'hE0, 8'hC0, 8'hF8, 8'h80, 8'h80};

	rtc_bcd_time_alarm_values #(.ADDR_WIDTH(12)) i_rtc_bcd_time_alarm_values (.clk_sys(clk_sys),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timebaseTick(timebaseTick),
		.timeNow(timeNow), .yearNow(yearNow), .alarmMatch(alarmMatch));

	initial forever #2 clk_sys = ~clk_sys;

	task stop_test;
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task check(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One idle edge first, so a strobe released by the previous call is never raised in the same step.
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 20)
		begin
			bad_count++;
			stop_test();
		end
		rdat = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		check(40'(rdat), 40'(exp));
	endtask

	function int rnd(input int n);
		return $unsigned($random(seed)) % n;
	endfunction

	function logic [7:0] img(input rtc_value_pkg::time_value_type t, input int k);
		case (k)
			0: return {2'h0, t.dayTensDigit, t.dayUnitsDigit};
			1: return {3'h0, t.monthTensDigit, t.monthUnitsDigit};
			2: return {2'h0, t.hourTensDigit, t.hourUnitsDigit};
			3: return {5'h00, t.weekdayDigit};
			4: return {1'h0, t.secondTensDigit, t.secondUnitsDigit};
			default: return {1'h0, t.minuteTensDigit, t.minuteUnitsDigit};
		endcase
	endfunction

	task loadAll(input logic [11:0] ctl, input logic [31:0] cv, input logic [11:0] base,
		input rtc_value_pkg::time_value_type t);
		xfer(ctl, 1'b1, cv);
		for (int k = 0; k < 6; k++)
			xfer(base + ((k % 2) ? 12'h004 : 12'h000), 1'b1, {24'hFFFFFF, img(t, k) | junkBits[k]});
		// Let the last write land before a caller compares timeNow in the same step as its edge.
		@(posedge clk_sys);
	endtask

	task readAll(input logic [11:0] ctl, input logic [31:0] cv, input logic [11:0] base,
		input rtc_value_pkg::time_value_type t);
		xfer(ctl, 1'b1, cv);
		for (int k = 0; k < 6; k++)
			rd(base + ((k % 2) ? 12'h004 : 12'h000), {24'h0, img(t, k)});
		rd(base + 12'h004, {24'h0, img(t, 5)});
	endtask

	task tickPulse;
		@(posedge clk_sys);
		timebaseTick <= 1'b1;
		repeat (6) @(posedge clk_sys);
		timebaseTick <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask

	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		expTime = {1'h0, 4'h1, 2'h0, 4'h1, 3'h0, 2'h0, 4'h0, 3'h0, 4'h0, 3'h0, 4'h0};
		@(posedge clk_sys);
		check(40'(timeNow), 40'(expTime));
		rd(`OFS_CLOCK_CONTROL, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			expTime = {1'(rnd(2)), 4'(rnd(10)), 2'(rnd(4)), 4'(rnd(10)), 3'(rnd(7)), 2'(rnd(3)), 4'(rnd(10)),
				3'(rnd(6)), 4'(rnd(10)), 3'(rnd(6)), 4'(rnd(10))};
			loadAll(`OFS_CLOCK_CONTROL, 32'h2200, `OFS_TIME_WINDOW_LOW, expTime);
			check(40'(timeNow), 40'(expTime));
			readAll(`OFS_CLOCK_CONTROL, 32'h2200, `OFS_TIME_WINDOW_LOW, expTime);
			loadAll(`OFS_ALARM_CONTROL, 32'h0200, `OFS_ALARM_WINDOW_LOW, expTime);
			readAll(`OFS_ALARM_CONTROL, 32'h0200, `OFS_ALARM_WINDOW_LOW, expTime);
			check(40'(alarmMatch), 40'h1);
		end
		xfer(`OFS_ALARM_WINDOW_LOW, 1'b1, {24'h0, img(expTime, 4) ^ 8'h01});
		repeat (2) @(posedge clk_sys);
		check(40'(alarmMatch), 40'h0);
		xfer(`OFS_ALARM_CONTROL, 1'b1, 32'h0300);
		rd(`OFS_ALARM_WINDOW_HIGH, 32'h0);
		rd(`OFS_ALARM_CONTROL, 32'h0200);
		other = {1'(rnd(2)), 4'(rnd(10)), 2'(rnd(4)), 4'(rnd(10)), 3'(rnd(7)), 2'(rnd(3)), 4'(rnd(10)),
			3'(rnd(6)), 4'(rnd(10)), 3'(rnd(6)), 4'(rnd(10))};
		loadAll(`OFS_CLOCK_CONTROL, 32'h0200, `OFS_TIME_WINDOW_LOW, other);
		expTime[13:0] = other[13:0];
		check(40'(timeNow), 40'(expTime));
		xfer(12'h018, 1'b0, 32'h0);
		// An unmapped read answers with the error flag and all-zero data.
		check(40'({errSeen, rdat}), 40'h0100000000);
		xfer(12'h7FC, 1'b1, 32'hFFFFFFFF);
		check(40'(errSeen), 40'h1);
		xfer(`OFS_CLOCK_CONTROL, 1'b1, 32'h2300);
		xfer(`OFS_TIME_WINDOW_LOW, 1'b1, 32'h99);
		expTime = {1'h1, 4'h2, 2'h3, 4'h1, 3'h6, 2'h2, 4'h3, 3'h5, 4'h9, 3'h5, 4'h9};
		loadAll(`OFS_CLOCK_CONTROL, 32'h2200, `OFS_TIME_WINDOW_LOW, expTime);
		tickPulse();
		rd(`OFS_CLOCK_CONTROL, 32'h2800);
		xfer(`OFS_TIME_WINDOW_LOW, 1'b1, 32'h59);
		rd(`OFS_CLOCK_CONTROL, 32'h2000);
		tickPulse();
		tickPulse();
		expTime = {1'h0, 4'h1, 2'h0, 4'h1, 3'h0, 2'h0, 4'h0, 3'h0, 4'h0, 3'h0, 4'h0};
		check(40'(timeNow), 40'(expTime));
		check(40'(yearNow), 40'h0);
		stop_test();
	end
endmodule

`default_nettype wire
